// ---- core/coc_console.sv ----
// Console operator control: manual sequencing and channel sense-switch service.
// Operation
// R01: Load lamp lit throughout program load.
// R02: Load fault leaves the load lamp lit.
// R03: Subsystem load needs state 0/1, test off.
// R04: Operator selects, sets interlock, then presses load.
// R05: System load needs interlock and enable held.
// R06: Accepted sense command returns all six switches.
// R07: Simultaneous channels: lowest number wins.
// R08: Losing channels get control unit busy.
// R09: Switch on gives one in its bit.
// R10: Odd byte parity on data, address keys.
// R11: Store writes data keys after stop, interlock.
// R12: Display reads keyed word after stop, interlock.
// R13: Invalid address suppresses store or display.
// R14: Invalid lamp holds until valid selection.
// R15: Unpowered, unconfigured or unmapped means invalid.
// R16: Odd parity added to control switch bits.
// R17: Activate loads control bits, clears state.
// R18: Set counter loads address keys into counter.
// R19: Busy answer is condition code two.
// R20: Answer only unit address 01.
// R21: Manual buttons ignored while interlock off.
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "coc_map.svh"
module coc_console (
    input  wire logic              pclk,
    input  wire logic              presetn,
    coc_if.dev                     pnl,
    input  wire logic [7:0]        ce_state,
    input  wire logic [3:0]        ce_test_sw,
    input  wire logic              sel_elem_powered,
    input  wire logic              sel_elem_configured,
    input  wire logic              sel_range_mapped,
    input  wire logic              ipl_done,
    input  wire logic              ipl_fault,
    input  wire logic              mem_ack,
    input  wire coc_pkg::coc_pword_t mem_rdata,
    output logic                   ipl_start,
    output logic                   ipl_system,
    output logic [1:0]             ipl_store,
    output logic [7:0]             ipl_unit,
    output coc_pkg::coc_ce_t       tgt_ce,
    output logic                   mem_req,
    output logic                   mem_write,
    output logic                   mem_local,
    output coc_pkg::coc_pword_t    mem_addr,
    output coc_pkg::coc_pword_t    mem_wdata,
    output logic                   cfg_we,
    output logic [8:0]             cfg_bits,
    output logic                   ic_we,
    output coc_pkg::coc_pword_t    ic_value
);
    import coc_pkg::*;

    // ************
    // Key parity and selection checks
    // ************
    logic [3:0]          dpar;
    logic [3:0]          apar;
    coc_pword_t          data_p;
    coc_pword_t          addr_p;
    logic                sel_ok;
    logic                ce_ok;

    // Each key byte gets its own odd parity bit, kept in the top nibble.
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb = gb + 1) begin : g_par
            assign dpar[gb] = ~^pnl.data_keys[8*gb +: 8]; // [R10]
            assign apar[gb] = ~^pnl.addr_keys[8*gb +: 8]; // [R10]
        end
    endgenerate
    assign data_p = {dpar, pnl.data_keys};
    assign addr_p = {apar, pnl.addr_keys};

    // A selection is good only if the target element is up, owned and mapped.
    assign sel_ok = sel_elem_powered & sel_elem_configured & sel_range_mapped; // [R15]
    // State 0 or 1 means the high state bit is clear.
    assign ce_ok  = ~ce_state[{pnl.ce_sel, 1'b1}] & ~ce_test_sw[pnl.ce_sel]; // [R03]

    // ************
    // Pushbutton edges and stop latch
    // ************
    logic [5:0]          pb_d_ff;
    logic [5:0]          pb_rise;
    logic                stopped_ff;
    coc_state_t          state_ff;

    // Buttons act on their press edge so a held button fires once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pb_d_ff <= 6'h00;
        end else begin
            pb_d_ff <= pnl.pb;
        end
    end
    assign pb_rise = pnl.pb & ~pb_d_ff;

    // Dropping the interlock forgets an earlier stop, so the sequence restarts.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stopped_ff <= 1'b0;
        end else if (!pnl.interlock) begin
            stopped_ff <= 1'b0; // [R21]
        end else if (pb_rise[`COC_PB_STOP]) begin
            stopped_ff <= 1'b1;
        end
    end

    // ************
    // Manual request decode, one request per idle cycle
    // ************
    logic                idle;
    logic                manual_ok;
    logic                ipl_go;
    logic                mem_try;
    logic                mem_go;
    logic                mem_bad;
    logic                act_go;
    logic                ic_go;

    assign idle      = (state_ff == COC_IDLE);
    assign manual_ok = idle & pnl.interlock & stopped_ff; // [R21]
    // System load bypasses the element state check; subsystem load does not.
    assign ipl_go    = idle & pnl.interlock & pb_rise[`COC_PB_LOAD] & (pnl.enable_sys | ce_ok); // [R03] [R05]
    assign mem_try   = manual_ok & ~ipl_go & (pb_rise[`COC_PB_STORE] | pb_rise[`COC_PB_DISPLAY]);
    assign mem_go    = mem_try & sel_ok;
    assign mem_bad   = mem_try & ~sel_ok; // [R13]
    assign act_go    = manual_ok & ~ipl_go & ~mem_try & pb_rise[`COC_PB_ACTIVATE];
    assign ic_go     = manual_ok & ~ipl_go & ~mem_try & ~act_go & pb_rise[`COC_PB_SETIC];

    // ************
    // Operation sequencer and element-side outputs
    // ************
    // Store and display hold the request until the element acknowledges.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff   <= COC_IDLE;
            ipl_start  <= 1'b0;
            ipl_system <= 1'b0;
            ipl_store  <= 2'h0;
            ipl_unit   <= 8'h00;
            tgt_ce     <= 2'h0;
            mem_req    <= 1'b0;
            mem_write  <= 1'b0;
            mem_local  <= 1'b0;
            mem_addr   <= 36'h0_0000_0000;
            mem_wdata  <= 36'h0_0000_0000;
            cfg_we     <= 1'b0;
            cfg_bits   <= 9'h000;
            ic_we      <= 1'b0;
            ic_value   <= 36'h0_0000_0000;
        end else begin
            ipl_start <= 1'b0;
            cfg_we    <= 1'b0;
            ic_we     <= 1'b0;
            case (state_ff)
                COC_IDLE: begin
                    if (ipl_go) begin
                        ipl_start  <= 1'b1; // [R05]
                        ipl_system <= pnl.enable_sys;
                        ipl_store  <= pnl.ms_sel;
                        ipl_unit   <= pnl.load_unit;
                        tgt_ce     <= pnl.ce_sel;
                        state_ff   <= COC_IPL;
                    end else if (mem_go) begin
                        mem_req   <= 1'b1;
                        mem_write <= pb_rise[`COC_PB_STORE]; // [R11] [R12]
                        mem_local <= pnl.local_sel;
                        mem_addr  <= addr_p;
                        mem_wdata <= data_p; // [R11]
                        tgt_ce    <= pnl.ce_sel;
                        state_ff  <= COC_MEM;
                    end else if (act_go) begin
                        // The element clears its state bits on this same strobe.
                        cfg_we   <= 1'b1; // [R17]
                        cfg_bits <= {~^pnl.ctl_sw, pnl.ctl_sw}; // [R16]
                        tgt_ce   <= pnl.ce_sel;
                    end else if (ic_go) begin
                        ic_we    <= 1'b1; // [R18]
                        ic_value <= addr_p;
                        tgt_ce   <= pnl.ce_sel;
                    end
                end
                COC_IPL: begin
                    if (ipl_done | ipl_fault) begin
                        state_ff <= COC_IDLE;
                    end
                end
                COC_MEM: begin
                    if (mem_ack) begin
                        mem_req  <= 1'b0;
                        state_ff <= COC_IDLE;
                    end
                end
                default: begin
                    state_ff <= COC_IDLE;
                end
            endcase
        end
    end

    // ************
    // Panel lamps and display register
    // ************
    // A faulted load leaves the lamp on as a visible warning until a later
    // load completes cleanly.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pnl.load_lamp <= 1'b0;
        end else if (ipl_go) begin
            pnl.load_lamp <= 1'b1; // [R01]
        end else if ((state_ff == COC_IPL) && ipl_done && !ipl_fault) begin
            pnl.load_lamp <= 1'b0; // [R01] [R02]
        end
    end

    // Only a later valid store or display turns the invalid lamp off.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pnl.invalid_lamp <= 1'b0;
        end else if (mem_bad) begin
            pnl.invalid_lamp <= 1'b1; // [R14]
        end else if (mem_go) begin
            pnl.invalid_lamp <= 1'b0; // [R14]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pnl.disp_word <= 36'h0_0000_0000;
        end else if ((state_ff == COC_MEM) && mem_ack && !mem_write) begin
            pnl.disp_word <= mem_rdata; // [R12]
        end
    end

    // ************
    // Channel arbitration and sense-switch answer
    // ************
    logic [2:0]          served_ff;
    logic [2:0]          want;
    logic [2:0]          win;
    logic [7:0]          win_cmd;

    // Channels addressing another unit are never answered at all.
    generate
        for (gb = 0; gb < `COC_NCH; gb = gb + 1) begin : g_ch
            assign want[gb] = pnl.ch_req[gb] & ~served_ff[gb]
                              & (pnl.ch_addr[8*gb +: 8] == `COC_CU_ADDR); // [R20]
            // One answer per request; the channel must drop it to ask again.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    served_ff[gb]      <= 1'b0;
                    pnl.ch_ack[gb]     <= 1'b0;
                    pnl.ch_cc[2*gb +: 2] <= `COC_CC_OK;
                end else begin
                    served_ff[gb]  <= pnl.ch_req[gb] & (served_ff[gb] | want[gb]);
                    pnl.ch_ack[gb] <= want[gb];
                    if (want[gb]) begin
                        pnl.ch_cc[2*gb +: 2] <= win[gb] ? `COC_CC_OK : `COC_CC_BUSY; // [R08] [R19]
                    end
                end
            end
        end
    endgenerate

    assign win = want & (~want + 3'h1); // [R07]

    always_comb begin
        win_cmd = 8'h00;
        for (int i = 0; i < `COC_NCH; i++) begin
            win_cmd = win_cmd | (pnl.ch_cmd[8*i +: 8] & {8{win[i]}});
        end
    end

    // Switch k lands in bit k, unused bits are zero, bit 8 carries odd parity.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pnl.ch_sense <= 9'h000;
        end else if ((win != 3'h0) && (win_cmd == `COC_CMD_SENSE)) begin
            pnl.ch_sense <= {~^pnl.sense_sw, 2'h0, pnl.sense_sw}; // [R06] [R09]
        end
    end

endmodule : coc_console

// ---- core/coc_map.svh ----
// Register offsets, field positions and fixed codes of the console operator control.
`ifndef COC_MAP_SVH
`define COC_MAP_SVH

// ****************************************************************
// Channel side codes
// ****************************************************************
`define COC_NCH          3
`define COC_CU_ADDR      8'h01
`define COC_CMD_SENSE    8'h00
`define COC_CC_OK        2'h0
`define COC_CC_BUSY      2'h2

// ****************************************************************
// Pushbutton bit positions (PUSH register and device edge vector)
// ****************************************************************
`define COC_PB_LOAD      0
`define COC_PB_STOP      1
`define COC_PB_STORE     2
`define COC_PB_DISPLAY   3
`define COC_PB_ACTIVATE  4
`define COC_PB_SETIC     5
`define COC_NPB          6

// ****************************************************************
// APB register offsets of the operator end
// ****************************************************************
`define COC_OFS_CTRL     8'h00
`define COC_OFS_PUSH     8'h04
`define COC_OFS_DATA     8'h08
`define COC_OFS_ADDR     8'h0C
`define COC_OFS_UNIT     8'h10
`define COC_OFS_STATUS   8'h14
`define COC_OFS_DISP     8'h18
`define COC_OFS_CHREQ    8'h1C
`define COC_OFS_CH0      8'h20

// ****************************************************************
// CTRL field positions and reset value
// ****************************************************************
`define COC_CTRL_ILOCK   0
`define COC_CTRL_ENSYS   1
`define COC_CTRL_LOCAL   2
`define COC_CTRL_CE_LSB  4
`define COC_CTRL_MS_LSB  6
`define COC_CTRL_SNS_LSB 8
`define COC_CTRL_SW_LSB  16
`define COC_CTRL_RESET   32'h0000_0000

// ****************************************************************
// CHx field positions
// ****************************************************************
`define COC_CH_CMD_LSB   8
`define COC_CH_SNS_LSB   16
`define COC_CH_CC_LSB    25
`define COC_CH_DONE      27
`define COC_CH_PEND      28

`endif

// ---- core/coc_pkg.sv ----
// Types shared by both ends of the console operator control.
package coc_pkg;
    typedef logic [31:0] coc_word_t;
    typedef logic [35:0] coc_pword_t;
    typedef logic [1:0]  coc_ce_t;
    typedef enum logic [1:0] {COC_IDLE, COC_IPL, COC_MEM} coc_state_t;
endpackage : coc_pkg

// ---- core/coc_if.sv ----
// Panel and channel wiring between the console and its operator side.
`timescale 1ns/1ps
interface coc_if;
    logic [1:0]  ce_sel;
    logic [1:0]  ms_sel;
    logic [7:0]  load_unit;
    logic        interlock;
    logic        enable_sys;
    logic        local_sel;
    logic [5:0]  pb;
    logic [31:0] data_keys;
    logic [31:0] addr_keys;
    logic [7:0]  ctl_sw;
    logic [5:0]  sense_sw;
    logic        load_lamp;
    logic        invalid_lamp;
    logic [35:0] disp_word;
    logic [2:0]  ch_req;
    logic [23:0] ch_addr;
    logic [23:0] ch_cmd;
    logic [2:0]  ch_ack;
    logic [5:0]  ch_cc;
    logic [8:0]  ch_sense;

    modport dev (input ce_sel, ms_sel, load_unit, interlock, enable_sys, local_sel, pb, data_keys,
                 addr_keys, ctl_sw, sense_sw, ch_req, ch_addr, ch_cmd,
                 output load_lamp, invalid_lamp, disp_word, ch_ack, ch_cc, ch_sense);
    modport ctl (output ce_sel, ms_sel, load_unit, interlock, enable_sys, local_sel, pb, data_keys,
                 addr_keys, ctl_sw, sense_sw, ch_req, ch_addr, ch_cmd,
                 input load_lamp, invalid_lamp, disp_word, ch_ack, ch_cc, ch_sense);
endinterface : coc_if

// ---- core/coc_operator.sv ----
// Operator and channel end: APB registers that drive the console panel and channel requests.
`timescale 1ns/1ps
`include "coc_map.svh"
module coc_operator (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire coc_pkg::coc_word_t pwdata,
    output coc_pkg::coc_word_t     prdata,
    output logic                   pready,
    output logic                   pslverr,
    coc_if.ctl                     pnl
);
    import coc_pkg::*;

    // ************
    // APB slave: registered answer, one access cycle
    // ************
    coc_word_t           ctrl_ff;
    coc_word_t           rd;
    logic                hit;
    logic                wr;
    logic [2:0]          done_ff;
    logic [5:0]          cc_ff;
    logic [26:0]         sns_ff;

    assign wr = psel & penable & pwrite & pready;

    always_comb begin
        rd  = 32'h0000_0000;
        hit = 1'b1;
        case (paddr)
            `COC_OFS_CTRL:   rd = ctrl_ff;
            `COC_OFS_PUSH:   rd = 32'h0000_0000;
            `COC_OFS_DATA:   rd = pnl.data_keys;
            `COC_OFS_ADDR:   rd = pnl.addr_keys;
            `COC_OFS_UNIT:   rd = {24'h00_0000, pnl.load_unit};
            `COC_OFS_STATUS: rd = {26'h000_0000, pnl.disp_word[35:32], pnl.invalid_lamp, pnl.load_lamp};
            `COC_OFS_DISP:   rd = pnl.disp_word[31:0];
            `COC_OFS_CHREQ:  rd = {29'h0000_0000, pnl.ch_req};
            default: begin
                hit = 1'b0;
                for (int i = 0; i < `COC_NCH; i++) begin
                    if (paddr == `COC_OFS_CH0 + 8'(4 * i)) begin
                        hit = 1'b1;
                        rd  = {3'h0, pnl.ch_req[i], done_ff[i], cc_ff[2*i +: 2], sns_ff[9*i +: 9],
                               pnl.ch_cmd[8*i +: 8], pnl.ch_addr[8*i +: 8]};
                    end
                end
            end
        endcase
    end

    // The answer is prepared in the setup cycle, so every access lasts one cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
            prdata  <= (psel & ~penable & ~pwrite) ? rd : 32'h0000_0000;
        end
    end

    // ************
    // Panel switches, keys and pushbuttons
    // ************
    // Switch levels mirror CTRL; pushbuttons are one-cycle presses.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff       <= `COC_CTRL_RESET;
            pnl.data_keys <= 32'h0000_0000;
            pnl.addr_keys <= 32'h0000_0000;
            pnl.load_unit <= 8'h00;
            pnl.pb        <= 6'h00;
        end else begin
            pnl.pb <= 6'h00;
            if (wr && hit) begin
                case (paddr)
                    `COC_OFS_CTRL: ctrl_ff       <= pwdata;
                    `COC_OFS_PUSH: pnl.pb        <= pwdata[5:0];
                    `COC_OFS_DATA: pnl.data_keys <= pwdata;
                    `COC_OFS_ADDR: pnl.addr_keys <= pwdata;
                    `COC_OFS_UNIT: pnl.load_unit <= pwdata[7:0];
                    default: begin
                        pnl.pb <= 6'h00;
                    end
                endcase
            end
        end
    end

    // System load wants enable held; software keeps ENSYS set across the LOAD press.
    assign pnl.interlock  = ctrl_ff[`COC_CTRL_ILOCK]; // [R04] [R05]
    assign pnl.enable_sys = ctrl_ff[`COC_CTRL_ENSYS]; // [R05]
    assign pnl.local_sel  = ctrl_ff[`COC_CTRL_LOCAL];
    assign pnl.ce_sel     = ctrl_ff[`COC_CTRL_CE_LSB +: 2];
    assign pnl.ms_sel     = ctrl_ff[`COC_CTRL_MS_LSB +: 2];
    assign pnl.sense_sw   = ctrl_ff[`COC_CTRL_SNS_LSB +: 6];
    assign pnl.ctl_sw     = ctrl_ff[`COC_CTRL_SW_LSB +: 8];

    // ************
    // Channel requesters
    // ************
    // A request stands until answered; done is sticky and an answer beats its clear.
    genvar gc;
    generate
        for (gc = 0; gc < `COC_NCH; gc = gc + 1) begin : g_ch
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pnl.ch_req[gc]        <= 1'b0;
                    pnl.ch_addr[8*gc +: 8] <= 8'h00;
                    pnl.ch_cmd[8*gc +: 8]  <= 8'h00;
                    done_ff[gc]           <= 1'b0;
                    cc_ff[2*gc +: 2]      <= 2'h0;
                    sns_ff[9*gc +: 9]     <= 9'h000;
                end else begin
                    if (pnl.ch_ack[gc]) begin
                        pnl.ch_req[gc]    <= 1'b0;
                        done_ff[gc]       <= 1'b1;
                        cc_ff[2*gc +: 2]  <= pnl.ch_cc[2*gc +: 2];
                        sns_ff[9*gc +: 9] <= pnl.ch_sense;
                    end else if (wr && paddr == `COC_OFS_CHREQ && pwdata[gc]) begin
                        pnl.ch_req[gc] <= 1'b1;
                        done_ff[gc]    <= 1'b0;
                    end
                    if (wr && paddr == `COC_OFS_CH0 + 8'(4 * gc)) begin
                        pnl.ch_addr[8*gc +: 8] <= pwdata[7:0];
                        pnl.ch_cmd[8*gc +: 8]  <= pwdata[`COC_CH_CMD_LSB +: 8];
                    end
                end
            end
        end
    endgenerate

endmodule : coc_operator

// ---- dv/coc_chk.sv ----
// Assertions on the wiring between the console and operator ends.
`timescale 1ns/1ps
module coc_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        interlock,
    input wire logic [5:0]  pb,
    input wire logic [5:0]  sense_sw,
    input wire logic [2:0]  ch_req,
    input wire logic [23:0] ch_addr,
    input wire logic [23:0] ch_cmd,
    input wire logic [2:0]  ch_ack,
    input wire logic [5:0]  ch_cc,
    input wire logic [8:0]  ch_sense,
    input wire logic        load_lamp
);
    // ********
    // Channel and lamp checks
    // ********
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Channel zero asks for the console's own unit address.
    sequence s_ask0;
        $rose(ch_req[0]) && ch_addr[7:0] == 8'h01;
    endsequence
    sequence s_pulse0;
        ch_ack[0] ##1 !ch_ack[0];
    endsequence
    chk_grant_next: assert property (s_ask0 |=> s_pulse0) else $error("no grant");
    chk_ack_addr: assert property (
        ch_ack[0] |-> $past(ch_req[0]) && $past(ch_addr[7:0]) == 8'h01) else $error("stray grant");
    chk_low_wins: assert property (
        ch_ack[0] && ch_ack[1] |-> ch_cc[1:0] == 2'h0 && ch_cc[3:2] == 2'h2) else $error("bad tie");
    chk_loser_busy: assert property (
        ch_ack[2] && |ch_ack[1:0] |-> ch_cc[5:4] == 2'h2) else $error("no busy");
    chk_sense_copy: assert property (
        ch_ack[0] && $past(ch_cmd[7:0]) == 8'h00 |-> ch_sense[5:0] == $past(sense_sw)) else $error("sense");
    chk_sense_par: assert property (
        |ch_ack |-> ch_sense[7:6] == 2'b00 && ^ch_sense == 1'b1) else $error("sense parity");
    // The lamp may only light from a load press made under interlock.
    chk_lamp_cause: assert property (
        $rose(load_lamp) |-> $past(pb[0]) && $past(interlock)) else $error("lamp");
    chk_ilock_lamp: assert property (
        !interlock && !load_lamp |=> !load_lamp) else $error("lamp unlocked");
endmodule : coc_chk

// ---- dv/console_operator_control_tb_top.sv ----
// Testbench joining the console end and the operator end.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; $display("BAD %0t %h", $time, a); end end
module console_operator_control_tb_top;
    import coc_pkg::*;
    logic       pclk, presetn, psel, penable, pwrite, pready, ipl_done, ipl_fault, mem_ack, mp;
    logic       ipl_start, ipl_system, mem_req, mem_write, cfg_we, ic_we, wr_q;
    logic [7:0] paddr, ce_state;
    logic [3:0] ts;
    logic [8:0] cfg_bits;
    coc_word_t  pwdata, prdata, q;
    coc_pword_t mem_wdata, ic_value, wd_q;
    int         err_count, compares, cyc, n_ipl, n_mem, n_cfg, n_ic;
    coc_if pnl();
    coc_operator u_coc_operator (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(), .pnl(pnl));
    coc_console u_coc_console (.pclk(pclk), .presetn(presetn), .pnl(pnl), .ce_state(ce_state), .ce_test_sw(ts),
        .sel_elem_powered(1'b1), .sel_elem_configured(1'b1), .sel_range_mapped(mp), .ipl_done(ipl_done),
        .ipl_fault(ipl_fault), .mem_ack(mem_ack), .mem_rdata(36'h5_DEAD_BEEF), .ipl_start(ipl_start),
        .ipl_system(ipl_system), .ipl_store(), .ipl_unit(), .tgt_ce(), .mem_req(mem_req), .mem_write(mem_write),
        .mem_local(), .mem_addr(), .mem_wdata(mem_wdata), .cfg_we(cfg_we), .cfg_bits(cfg_bits), .ic_we(ic_we),
        .ic_value(ic_value));
    coc_chk u_coc_chk (.pclk(pclk), .presetn(presetn), .interlock(pnl.interlock), .pb(pnl.pb),
        .sense_sw(pnl.sense_sw), .ch_req(pnl.ch_req), .ch_addr(pnl.ch_addr), .ch_cmd(pnl.ch_cmd),
        .ch_ack(pnl.ch_ack), .ch_cc(pnl.ch_cc), .ch_sense(pnl.ch_sense), .load_lamp(pnl.load_lamp));
    // ********
    // Clock, element stand-in and cycle limit
    // ********
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Storage answers in one cycle; tallies count pulses since the bench cannot wait on them.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        mem_ack <= mem_req && !mem_ack;
        n_ipl <= n_ipl + int'(ipl_start);
        n_cfg <= n_cfg + int'(cfg_we);
        n_ic <= n_ic + int'(ic_we);
        if (mem_req && !mem_ack) begin
            n_mem <= n_mem + 1;
            wr_q <= mem_write;
            wd_q <= mem_wdata;
        end
        if (cyc == 3000) begin
            err_count++;
            wrap_up();
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input coc_word_t d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Press one button, then give the console time to act on it.
    task automatic press(input int b);
        apb(1'b1, 8'h04, 32'h1 << b);
        repeat (4) @(posedge pclk);
    endtask : press
    task automatic t_load;
        press(0);
        `CHK(n_ipl, 0)
        apb(1'b1, 8'h00, 32'h1);
        ce_state <= 8'h02;
        press(0);
        `CHK(n_ipl, 0)
        ce_state <= 8'h01;
        ts <= 4'h1;
        press(0);
        `CHK(n_ipl, 0)
        ts <= 4'h0;
        press(0);
        apb(1'b0, 8'h14, 32'h0);
        `CHK({n_ipl, q[0]}, {32'd1, 1'b1})
        ipl_fault <= 1'b1;
        @(posedge pclk);
        ipl_fault <= 1'b0;
        apb(1'b0, 8'h14, 32'h0);
        `CHK(q[0], 1'b1)
        ce_state <= 8'h02;
        apb(1'b1, 8'h00, 32'h3);
        press(0);
        `CHK({n_ipl, ipl_system}, {32'd2, 1'b1})
        ipl_done <= 1'b1;
        @(posedge pclk);
        ipl_done <= 1'b0;
        apb(1'b0, 8'h14, 32'h0);
        `CHK(q[0], 1'b0)
    endtask : t_load
    task automatic t_mem;
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h08, 32'h0100_03FF);
        apb(1'b1, 8'h0C, 32'h0000_0010);
        press(2);
        `CHK(n_mem, 0)
        press(1);
        press(2);
        `CHK({n_mem, wr_q, wd_q}, {32'd1, 1'b1, 36'h7_0100_03FF})
        press(3);
        apb(1'b0, 8'h18, 32'h0);
        `CHK({n_mem, wr_q, q}, {32'd2, 1'b0, 32'hDEAD_BEEF})
        mp <= 1'b0;
        press(2);
        apb(1'b0, 8'h14, 32'h0);
        `CHK({n_mem, q[1]}, {32'd2, 1'b1})
        mp <= 1'b1;
        press(3);
        apb(1'b0, 8'h14, 32'h0);
        `CHK({n_mem, q[1]}, {32'd3, 1'b0})
        apb(1'b1, 8'h00, 32'h0003_0001);
        press(4);
        `CHK({n_cfg, cfg_bits}, {32'd1, 9'h103})
        press(5);
        `CHK({n_ic, ic_value}, {32'd1, 36'hE_0000_0010})
        apb(1'b1, 8'h00, 32'h0);
        press(4);
        `CHK(n_cfg, 1)
    endtask : t_mem
    task automatic t_chan;
        apb(1'b1, 8'h00, 32'h0000_2500);
        for (int i = 0; i < 3; i++) apb(1'b1, 8'h20 + 8'(4 * i), 32'h1);
        apb(1'b1, 8'h1C, 32'h7);
        repeat (2) @(posedge pclk);
        apb(1'b0, 8'h20, 32'h0);
        `CHK(q[27:16], 12'h825)
        apb(1'b0, 8'h24, 32'h0);
        `CHK(q[27:25], 3'h6)
        apb(1'b0, 8'h28, 32'h0);
        `CHK(q[27:25], 3'h6)
        apb(1'b1, 8'h20, 32'h2);
        apb(1'b1, 8'h1C, 32'h1);
        repeat (4) @(posedge pclk);
        apb(1'b0, 8'h1C, 32'h0);
        `CHK(q[0], 1'b1)
    endtask : t_chan
    task automatic wrap_up;
        if (err_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up
    // Reset for ten cycles, then run each scenario in turn.
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ce_state, ts, ipl_done, ipl_fault} = '0;
        mp = 1'b1;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_load();
        t_mem();
        t_chan();
        wrap_up();
    end
endmodule : console_operator_control_tb_top
